// ---- dv/ilp_check_sva.sv ----
// Purpose: Port assertions for the lane parity checker.
// Assumes: One core clock and an active-low reset.
// Notes:   Bound to every instance of the checker top.
`timescale 1ns/1ps
module ilp_check_sva #(
	parameter int unsigned LANES = 4
) (
	input wire logic             i_core_clk,
	input wire logic             i_rst_n,
	input wire logic             i_lane_mode_select,
	input wire logic [LANES-1:0] i_parity_err_clear,
	input wire logic [LANES-1:0] o_parity_err_sticky,
	input wire logic [LANES-1:0] o_parity_err_pulse,
	input wire logic [LANES-1:0] o_lane_checked,
	input wire logic             o_four_lane_mode
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	a_pulse_has_check: assert property (
		(o_parity_err_pulse & ~o_lane_checked) == '0) else $error("pulse");
	a_sticky_on_pulse: assert property (
		(o_parity_err_pulse & ~o_parity_err_sticky) == '0) else $error("set");
	a_sticky_rise_cause: assert property (
		(o_parity_err_sticky & ~$past(o_parity_err_sticky)
		& ~o_parity_err_pulse) == '0) else $error("rise");
	a_sticky_holds: assert property (|o_parity_err_sticky |=>
		($past(o_parity_err_sticky) & ~$past(i_parity_err_clear)
		& ~o_parity_err_sticky) == '0) else $error("hold");
	a_clear_works: assert property (|i_parity_err_clear |=>
		((o_parity_err_sticky ^ o_parity_err_pulse)
		& $past(i_parity_err_clear)) == '0) else $error("clear");
	a_single_lane_only: assert property (
		!o_four_lane_mode && !$past(o_four_lane_mode) |->
		o_lane_checked[LANES-1:1] == '0) else $error("single");
	a_four_lane_all: assert property (
		o_four_lane_mode && $past(o_four_lane_mode) && o_lane_checked[0]
		|-> &o_lane_checked) else $error("four");
	a_check_one_cycle: assert property (
		o_lane_checked[0] |=> !o_lane_checked[0]) else $error("width");
	a_mode_follows: assert property (
		$rose(i_lane_mode_select) |-> ##[1:5] o_four_lane_mode)
		else $error("mode");
	cover property (o_four_lane_mode && o_lane_checked[LANES-1]);
	cover property (!o_four_lane_mode && o_lane_checked[0]);
	cover property (|o_parity_err_pulse);
endmodule

bind ilp_incoming_lane_parity_check ilp_check_sva #(.LANES(LANES)) sva_i (
	.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
	.i_lane_mode_select(i_lane_mode_select),
	.i_parity_err_clear(i_parity_err_clear),
	.o_parity_err_sticky(o_parity_err_sticky),
	.o_parity_err_pulse(o_parity_err_pulse),
	.o_lane_checked(o_lane_checked), .o_four_lane_mode(o_four_lane_mode));

// ---- dv/ilp_upstream_model.sv ----
// Purpose: Upstream framer model driving the incoming byte lanes.
// Assumes: Byte clock period of eight core cycles.
// Notes:   i_flip inverts chosen lane parities to inject errors.
`timescale 1ns/1ps
module ilp_upstream_model (
	input  wire logic        i_core_clk,
	input  wire logic        i_mode,
	input  wire logic [39:0] i_rand,
	input  wire logic [3:0]  i_inc_m,
	input  wire logic [3:0]  i_inc_p,
	input  wire logic [3:0]  i_odd,
	input  wire logic [3:0]  i_flip,
	output logic             o_stm1_clk,
	output logic             o_stm4_clk,
	output logic [31:0]      o_data,
	output logic [3:0]       o_marker,
	output logic [3:0]       o_payload,
	output logic [3:0]       o_parity
);
	logic [2:0] ph;
	initial {ph, o_stm1_clk, o_stm4_clk, o_data, o_marker, o_payload,
		o_parity} = '0;
	// Pins move on the core clock rise, while the bench sets its controls
	// on the fall, so the model never races the bench for a control value.
	always @(posedge i_core_clk) begin
		ph <= ph + 3'h1;
		if (ph == 3'h0) begin
			o_stm1_clk <= 1'b0;
			o_stm4_clk <= 1'b0;
			o_data <= i_rand[31:0];
			o_marker <= i_rand[35:32];
			o_payload <= i_rand[39:36];
			for (int n = 0; n < 4; n++) begin
				o_parity[n] <= ^i_rand[8*n+:8] ^ i_odd[n] ^ i_flip[n]
					^ (i_inc_m[n] & i_rand[32+n])
					^ (i_inc_p[n] & i_rand[36+n]);
			end
			if (!i_mode)
				o_parity[3:1] <= 3'h0;
		end else if (ph == 3'h4) begin
			o_stm1_clk <= i_mode;
			o_stm4_clk <= !i_mode;
		end
	end
endmodule

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the lane parity checker.
// Assumes: The upstream model drives every lane pin.
// Notes:   Verdicts wait two checks so in-flight bytes drain first.
`timescale 1ns/1ps
module tb_top;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        mode = 1'b1;
	logic [3:0]  inc_m = 4'h0, inc_p = 4'h0, odd = 4'h0;
	logic [3:0]  flip = 4'h0, clr = 4'h0;
	logic [39:0] rnd = 40'h0;
	logic        b1, b4, fl;
	logic [31:0] data;
	logic [3:0]  mk, pl, par, stk, err, chk, want;
	int          n_errors = 0, n_compared = 0, seed = 99097;
	ilp_upstream_model ilp_upstream_model_i (.i_core_clk(clk), .i_mode(mode),
		.i_rand(rnd), .i_inc_m(inc_m), .i_inc_p(inc_p), .i_odd(odd),
		.i_flip(flip), .o_stm1_clk(b1), .o_stm4_clk(b4), .o_data(data),
		.o_marker(mk), .o_payload(pl), .o_parity(par));
	ilp_incoming_lane_parity_check ilp_incoming_lane_parity_check_i (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_stm1_byte_clock(b1),
		.i_stm4_byte_clock(b4), .i_lane_mode_select(mode),
		.i_lane_data_in(data), .i_frame_marker_in(mk),
		.i_payload_indicator_in(pl), .i_lane_parity_in(par),
		.i_parity_include_marker(inc_m), .i_parity_include_payload(inc_p),
		.i_parity_odd_select(odd), .i_parity_err_clear(clr),
		.o_parity_err_sticky(stk), .o_parity_err_pulse(err),
		.o_lane_checked(chk), .o_four_lane_mode(fl));
	always #5 clk = ~clk;
	always @(negedge clk) rnd <= 40'({$random(seed), $random(seed)});
	function automatic logic [3:0] lanes(input logic m);
		return m ? 4'hF : 4'h1;
	endfunction
	task automatic final_report();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wait_check();
		int k;
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (chk[0] !== 1'b1 && k < 300);
		if (k >= 300) begin
			n_errors++;
			$display("wrong value check expected pulse seen none");
			final_report();
		end
	endtask
	task automatic run(input logic m, input int iters);
		for (int i = 0; i < iters; i++) begin
			@(negedge clk);
			mode = m;
			{inc_m, inc_p, odd} = 12'($random(seed));
			// A byte framed under the old options may still be in flight,
			// so let it drain and clear its flags before injecting errors.
			wait_check();
			@(negedge clk);
			clr = 4'hF;
			@(negedge clk);
			clr = 4'h0;
			flip = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($random(seed));
			want = flip & lanes(m);
			wait_check();
			wait_check();
			check("checked", chk, lanes(m));
			check("pulse", err, want);
			check("sticky", stk, want);
			check("mode", fl, m);
			@(negedge clk);
			flip = 4'h0;
			wait_check();
			wait_check();
			@(negedge clk);
			clr = 4'hF;
			@(negedge clk);
			clr = 4'h0;
			check("cleared", stk, 4'h0);
		end
	endtask
	initial begin
		repeat (4) @(negedge clk);
		check("reset", {stk, chk}, 8'h00);
		rst_n = 1'b1;
		run(1'b1, 12);
		run(1'b0, 8);
		run(1'b1, 4);
		final_report();
	end
endmodule

// ---- logic/ilp_incoming_lane_parity_check.sv ----
// Purpose: Parity checker for the incoming byte-wide SONET/SDH lanes.
// Assumes: Lane pins and byte clocks are asynchronous to i_core_clk,
//          which is at least twice as fast as the fastest byte clock.
// Notes:   Configuration and clear inputs come from core-clock logic.
//
// Functional notes
// - Mode select high gives four STM-1 lanes, low one STM-4 lane.
// - Four-lane mode: lane 2 parity over data 15:8 plus optional signals.
// - Four-lane mode: lane 3 parity over data 23:16 plus optional signals.
// - Four-lane mode: lane 4 parity over data 31:24 plus optional signals.
// - Marker and payload enter parity only when their include bit is set.
// - Per lane, odd parity when sense bit high, else even parity.
// - Four-lane mode samples lanes 2 to 4 on the STM-1 clock edge.
// - Lane 1 covers data 7:0; STM-4 mode samples it on the fast clock.
`timescale 1ns/1ps
module ilp_incoming_lane_parity_check #(
	parameter int unsigned LANES = ilp_pkg::LANE_COUNT,
	parameter int unsigned WIDTH = ilp_pkg::LANE_WIDTH
) (
	input  wire logic                   i_core_clk,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_stm1_byte_clock,
	input  wire logic                   i_stm4_byte_clock,
	input  wire logic                   i_lane_mode_select,
	input  wire logic [LANES*WIDTH-1:0] i_lane_data_in,
	input  wire logic [LANES-1:0]       i_frame_marker_in,
	input  wire logic [LANES-1:0]       i_payload_indicator_in,
	input  wire logic [LANES-1:0]       i_lane_parity_in,
	input  wire logic [LANES-1:0]       i_parity_include_marker,
	input  wire logic [LANES-1:0]       i_parity_include_payload,
	input  wire logic [LANES-1:0]       i_parity_odd_select,
	input  wire logic [LANES-1:0]       i_parity_err_clear,
	output logic      [LANES-1:0]       o_parity_err_sticky,
	output logic      [LANES-1:0]       o_parity_err_pulse,
	output logic      [LANES-1:0]       o_lane_checked,
	output logic                        o_four_lane_mode
);

	localparam int unsigned PIN_W = LANES * WIDTH + 3 * LANES + 3;

	// Every pin passes the same two flops, so data and clocks keep their
	// relative alignment; the byte clock edge is then found on stage two.
	logic [PIN_W-1:0] pins;
	logic [PIN_W-1:0] sync1_d;
	logic [PIN_W-1:0] sync1_q;
	logic [PIN_W-1:0] sync2_d;
	logic [PIN_W-1:0] sync2_q;

	logic [LANES*WIDTH-1:0] data_s;
	logic [LANES-1:0]       marker_s;
	logic [LANES-1:0]       payload_s;
	logic [LANES-1:0]       parity_s;
	logic                   stm1_clk_s;
	logic                   stm4_clk_s;
	logic                   mode_s;

	assign pins = {i_lane_mode_select, i_stm4_byte_clock,
		i_stm1_byte_clock, i_lane_parity_in, i_payload_indicator_in,
		i_frame_marker_in, i_lane_data_in};

	always_comb begin
		sync1_d = pins;
		sync2_d = sync1_q;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
		end
	end

	assign {mode_s, stm4_clk_s, stm1_clk_s, parity_s, payload_s,
		marker_s, data_s} = sync2_q;

	// Edge history of the two byte clocks, read from stage two only.
	logic [1:0] clk_hist_d;
	logic [1:0] clk_hist_q;
	logic       stm1_rise;
	logic       stm4_rise;

	always_comb begin
		clk_hist_d = {stm4_clk_s, stm1_clk_s};
		stm1_rise = stm1_clk_s & ~clk_hist_q[0];
		stm4_rise = stm4_clk_s & ~clk_hist_q[1];
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			clk_hist_q <= ilp_pkg::EDGE_HIST_RST;
		end else begin
			clk_hist_q <= clk_hist_d;
		end
	end

	// After reset or a mode change the source needs a couple of byte clock
	// edges to realign, so checking waits rather than flagging junk.
	ilp_pkg::ilp_state_e state_d;
	ilp_pkg::ilp_state_e state_q;
	logic                mode_d;
	logic                mode_q;
	logic [ilp_pkg::SETTLE_WIDTH-1:0] settle_d;
	logic [ilp_pkg::SETTLE_WIDTH-1:0] settle_q;
	logic                mode_edge;

	always_comb begin
		mode_d = mode_s;
		state_d = state_q;
		settle_d = settle_q;
		// Mode high means four separate lanes, low one fast lane.
		mode_edge = mode_s ? stm1_rise : stm4_rise;
		case (state_q)
			ilp_pkg::ILP_MODE_IDLE: begin
				settle_d = ilp_pkg::SETTLE_LOAD;
				state_d = ilp_pkg::ILP_MODE_SETTLE;
			end
			ilp_pkg::ILP_MODE_SETTLE: begin
				if (mode_s != mode_q) begin
					settle_d = ilp_pkg::SETTLE_LOAD;
				end else if (mode_edge) begin
					settle_d = settle_q - 1'b1;
					if (settle_q == 2'h1) begin
						state_d = ilp_pkg::ILP_MODE_RUN;
					end
				end
			end
			ilp_pkg::ILP_MODE_RUN: begin
				if (mode_s != mode_q) begin
					settle_d = ilp_pkg::SETTLE_LOAD;
					state_d = ilp_pkg::ILP_MODE_SETTLE;
				end
			end
			default: begin
				state_d = ilp_pkg::ILP_MODE_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= ilp_pkg::ILP_MODE_IDLE;
			mode_q <= ilp_pkg::MODE_RST;
			settle_q <= ilp_pkg::SETTLE_RST;
		end else begin
			state_q <= state_d;
			mode_q <= mode_d;
			settle_q <= settle_d;
		end
	end

	// Per-lane sample strobes.
	logic [LANES-1:0] sample;
	logic             run;

	always_comb begin
		run = (state_q == ilp_pkg::ILP_MODE_RUN) && (mode_s == mode_q);
		sample = '0;
		if (run && mode_q) begin
			// All four lanes on the STM-1 byte clock.
			sample = {LANES{stm1_rise}};
		end else if (run) begin
			// Only lane 1, on the fast clock; lanes 2 to 4 are ignored,
			// whatever their pins carry, since their strobes stay low.
			sample[0] = stm4_rise;
		end
	end

	// Lane n checks data bits n*8-1:n*8-8 with its own options; lane 1 is
	// 7:0, lane 2 15:8, lane 3 23:16, lane 4 31:24.
	// Correctness depends on the source pairing each parity bit with its
	// own lane on the same edge.
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		ilp_lane_check #(
			.WIDTH(WIDTH)
		) u_lane (
			.i_core_clk   (i_core_clk),
			.i_rst_n      (i_rst_n),
			.i_sample     (sample[g]),
			.i_data       (data_s[g*WIDTH +: WIDTH]),
			.i_marker     (marker_s[g]),
			.i_payload    (payload_s[g]),
			.i_parity     (parity_s[g]),
			.i_inc_marker (i_parity_include_marker[g]),
			.i_inc_payload(i_parity_include_payload[g]),
			.i_odd        (i_parity_odd_select[g]),
			.i_clear      (i_parity_err_clear[g]),
			.o_err_sticky (o_parity_err_sticky[g]),
			.o_err_pulse  (o_parity_err_pulse[g])
		);
	end

	// Registered strobe of checks performed, for counting by software.
	logic [LANES-1:0] checked_d;
	logic [LANES-1:0] checked_q;
	logic             four_d;
	logic             four_q;

	always_comb begin
		checked_d = sample;
		four_d = mode_q;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			checked_q <= ilp_pkg::PULSE_RST;
			four_q <= ilp_pkg::MODE_RST;
		end else begin
			checked_q <= checked_d;
			four_q <= four_d;
		end
	end

	assign o_lane_checked = checked_q;
	assign o_four_lane_mode = four_q;

endmodule

// ---- logic/ilp_lane_check.sv ----
// Purpose: Parity check of one byte lane with optional marker and payload.
// Assumes: Inputs are already synchronised to i_core_clk.
// Notes:   Checks only in the cycle that i_sample is high.
`timescale 1ns/1ps
module ilp_lane_check #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_sample,
	input  wire logic [WIDTH-1:0] i_data,
	input  wire logic             i_marker,
	input  wire logic             i_payload,
	input  wire logic             i_parity,
	input  wire logic             i_inc_marker,
	input  wire logic             i_inc_payload,
	input  wire logic             i_odd,
	input  wire logic             i_clear,
	output logic                  o_err_sticky,
	output logic                  o_err_pulse
);

	logic sum;
	logic mismatch;
	logic sticky_d;
	logic sticky_q;
	logic pulse_d;
	logic pulse_q;

	always_comb begin
		// Marker and payload join the sum only when enabled.
		sum = ^i_data ^ (i_inc_marker & i_marker)
			^ (i_inc_payload & i_payload) ^ i_parity;
		// Odd sense expects a total of one, even sense a total of zero.
		mismatch = sum ^ i_odd;
		pulse_d = i_sample & mismatch;
		// A new error beats a clear in the same cycle.
		if (pulse_d) begin
			sticky_d = 1'b1;
		end else if (i_clear) begin
			sticky_d = 1'b0;
		end else begin
			sticky_d = sticky_q;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sticky_q <= ilp_pkg::FLAG_RST;
			pulse_q <= ilp_pkg::FLAG_RST;
		end else begin
			sticky_q <= sticky_d;
			pulse_q <= pulse_d;
		end
	end

	assign o_err_sticky = sticky_q;
	assign o_err_pulse = pulse_q;

endmodule

// ---- logic/ilp_pkg.sv ----
// Purpose: Shared constants for the incoming lane parity checker.
// Assumes: Four byte lanes, one core clock at 100 MHz.
// Notes:   Reset values and widths are named here once.
package ilp_pkg;

	localparam int unsigned LANE_COUNT = 4;
	localparam int unsigned LANE_WIDTH = 8;
	localparam int unsigned DATA_WIDTH = LANE_COUNT * LANE_WIDTH;
	localparam int unsigned SETTLE_EDGES = 2;
	localparam int unsigned SETTLE_WIDTH = 2;

	localparam logic [3:0] STICKY_RST = 4'h0;
	localparam logic [3:0] PULSE_RST = 4'h0;
	localparam logic [1:0] SETTLE_RST = 2'h0;
	localparam logic [1:0] SETTLE_LOAD = 2'h2;
	localparam logic [1:0] EDGE_HIST_RST = 2'h0;
	localparam logic MODE_RST = 1'b0;
	localparam logic FLAG_RST = 1'b0;

	typedef enum logic [1:0] {
		ILP_MODE_IDLE,
		ILP_MODE_SETTLE,
		ILP_MODE_RUN
	} ilp_state_e;

endpackage
